// *** common/psbp_pkg.sv ***
// shared constants of the pipelined burst sram port
package psbp_pkg;
	// burst counter width and burst length
	localparam int BURST_W     = 2;
	localparam int BURST_LEN   = 4;
	// 256k x 36 organisation
	localparam int ADDR_W_X36  = 18;
	localparam int DATA_W_X36  = 36;
	localparam int LANES_X36   = 4;
	// 512k x 18 organisation
	localparam int ADDR_W_X18  = 19;
	localparam int DATA_W_X18  = 18;
	localparam int LANES_X18   = 2;
	// one byte lane carries eight data bits and a parity bit
	localparam int BYTE_W      = 9;
	// three chip selects, all active low
	localparam int CS_W        = 3;
	localparam logic [2:0] CS_ALL_ON = 3'h0;
	// cycles from strobe capture to first data word
	localparam int FIRST_WORD_CYC = 3;
	// reset values
	localparam logic [1:0] CNT_RST = 2'h0;
endpackage

// *** design/psbp_burst_counter.sv ***
// two-bit burst address counter with interleaved or linear order
`timescale 1ns/1ps
module psbp_burst_counter
	import psbp_pkg::*;
#(
	parameter int CNT_W = BURST_W
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// control
	input  wire logic             load,
	input  wire logic             step,
	input  wire logic             linearOrder,
	// start offset and current offset
	input  wire logic [CNT_W-1:0] startLow,
	output logic      [CNT_W-1:0] burstLow
);
	logic [CNT_W-1:0] start_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;

	// reload abandons any burst, otherwise step on request
	assign count_nxt = load ? CNT_W'(0) : (step ? count_r + CNT_W'(1) : count_r);

	// offset walks from the start, wrapping within four words
	assign burstLow = linearOrder ? start_r + count_r : start_r ^ count_r;

	// counter and start registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			start_r <= CNT_W'(CNT_RST);
			count_r <= CNT_W'(CNT_RST);
		end else begin
			count_r <= count_nxt;
			if (load) begin
				start_r <= startLow;
			end
		end
	end
endmodule // psbp_burst_counter

// *** design/psbp_sram_port.sv ***
// pipelined burst sram port with byte writes and single cycle deselect
//
// Function
// - register all synchronous inputs on rising edge
// - either strobe loads address and chip selects
// - later burst addresses generated internally on advance
// - two-bit counter on low address bits
// - burst order interleaved or linear by input
// - writes registered then completed internally
// - only selected bytes are written
// - global write low writes all bytes
// - output enable and sleep act asynchronously
// - read data leaves through output register
// - burst timing is three then one each
// - deselect stops driving within one cycle
// - respond only when all chip selects active
// - array is 256k x 36 or 512k x 18
`timescale 1ns/1ps
module psbp_sram_port
	import psbp_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_X36,
	parameter int DATA_W = DATA_W_X36,
	parameter int LANES  = LANES_X36
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// address and strobes
	input  wire logic [ADDR_W-1:0] addrIn,
	input  wire logic              processorAddrStrobe_n,
	input  wire logic              controllerAddrStrobe_n,
	input  wire logic              burstAdvance_n,
	input  wire logic              burstOrderLinear,
	// chip selects
	input  wire logic              pipelineChipSelect_n,
	input  wire logic              depthChipSelectHi_n,
	input  wire logic              depthChipSelectLo_n,
	// write controls
	input  wire logic [LANES-1:0]  byteWriteSelect_n,
	input  wire logic              byteWriteGate_n,
	input  wire logic              globalWrite_n,
	// asynchronous controls
	input  wire logic              outputEnable_n,
	input  wire logic              sleepRequest,
	// data pins split into in, out and enable
	input  wire logic [DATA_W-1:0] dqIn,
	output logic      [DATA_W-1:0] dqOut,
	output logic                   dqOe_n
);
	localparam int LANE_W = DATA_W / LANES;

	// registered pins
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] dataIn_r;
	logic              procStb_r;
	logic              ctrlStb_r;
	logic              adv_r;
	logic              linear_r;
	logic [CS_W-1:0]   cs_r;
	logic [LANES-1:0]  bws_r;
	logic              bwGate_r;
	logic              gw_r;
	// sleep synchroniser
	logic              sleepMeta_r;
	logic              sleepSync_r;
	// burst state
	logic              active_r;
	logic [ADDR_W-BURST_W-1:0] base_r;
	logic [BURST_W-1:0] burstLow;
	// array access stage
	logic              accValid_r;
	logic [LANES-1:0]  accLanes_r;
	logic [DATA_W-1:0] accData_r;
	// read and output stages
	logic [DATA_W-1:0] readData_r;
	logic              readValid_r;
	logic [DATA_W-1:0] outData_r;
	logic              outValid_r;
	// storage array
	logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

	// decode of the registered controls
	wire strobeHit  = ~(procStb_r & ctrlStb_r) & ~sleepSync_r;
	wire csAll      = (cs_r == CS_ALL_ON);
	wire startHit   = strobeHit & csAll;
	wire deselHit   = strobeHit & ~csAll;
	wire stepHit    = active_r & ~strobeHit & ~adv_r;
	wire accessNow  = (startHit | (active_r & ~strobeHit)) & ~sleepSync_r;
	wire [LANES-1:0] wrLanes = ~gw_r ? {LANES{1'b1}} :
		(~bwGate_r ? ~bws_r : {LANES{1'b0}});
	wire [ADDR_W-1:0] accAddr = {base_r, burstLow};

	// every synchronous input captured on the rising edge
	always_ff @(posedge ref_clk) begin
		addr_r    <= addrIn;
		dataIn_r  <= dqIn;
		procStb_r <= rst ? 1'b1 : processorAddrStrobe_n;
		ctrlStb_r <= rst ? 1'b1 : controllerAddrStrobe_n;
		adv_r     <= rst ? 1'b1 : burstAdvance_n;
		linear_r  <= rst ? 1'b0 : burstOrderLinear;
		cs_r      <= rst ? {CS_W{1'b1}} :
			{pipelineChipSelect_n, depthChipSelectHi_n, depthChipSelectLo_n};
		bws_r     <= rst ? {LANES{1'b1}} : byteWriteSelect_n;
		bwGate_r  <= rst ? 1'b1 : byteWriteGate_n;
		gw_r      <= rst ? 1'b1 : globalWrite_n;
	end

	// two flops before sleep reaches clocked logic
	always_ff @(posedge ref_clk) begin
		sleepMeta_r <= rst ? 1'b0 : sleepRequest;
		sleepSync_r <= rst ? 1'b0 : sleepMeta_r;
	end

	// burst address counter
	psbp_burst_counter #(
		.CNT_W       (BURST_W)
	) u_counter (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.load        (startHit),
		.step        (stepHit),
		.linearOrder (linear_r),
		.startLow    (addr_r[BURST_W-1:0]),
		.burstLow    (burstLow)
	);

	// burst state and upper address
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			active_r <= 1'b0;
			base_r   <= '0;
		end else begin
			if (startHit) begin
				active_r <= 1'b1;
				base_r   <= addr_r[ADDR_W-1:BURST_W];
			end else if (deselHit) begin
				active_r <= 1'b0;
			end
		end
	end

	// access stage holds lanes and data for the self-timed write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			accValid_r <= 1'b0;
			accLanes_r <= '0;
			accData_r  <= '0;
		end else begin
			accValid_r <= accessNow;
			accLanes_r <= accessNow ? wrLanes : '0;
			accData_r  <= dataIn_r;
		end
	end

	// array write, lane by lane
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (accValid_r && accLanes_r[i]) begin
				mem[accAddr][i*LANE_W +: LANE_W] <= accData_r[i*LANE_W +: LANE_W];
			end
		end
	end

	// array read then output register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			readData_r  <= '0;
			readValid_r <= 1'b0;
			outData_r   <= '0;
			outValid_r  <= 1'b0;
		end else begin
			readData_r  <= mem[accAddr];
			readValid_r <= accValid_r & ~(|accLanes_r) & ~deselHit;
			outData_r   <= readData_r;
			outValid_r  <= readValid_r & ~deselHit;
		end
	end

	// drive pins; enable and sleep bypass the clock
	assign dqOut  = outData_r;
	assign dqOe_n = ~(outValid_r & ~outputEnable_n & ~sleepRequest);

	// inputs appear in the capture registers one edge later
	chk_input_capture: assert property (
		@(posedge ref_clk) disable iff (rst)
		##1 (addr_r == $past(addrIn)) && (dataIn_r == $past(dqIn)))
		else $error("input capture register does not follow pins");

	// strobe with all selects active starts a burst at the given base
	chk_strobe_load: assert property (
		@(posedge ref_clk) disable iff (rst)
		startHit |=> active_r && (base_r == $past(addr_r[ADDR_W-1:BURST_W]))
			&& (burstLow == $past(addr_r[BURST_W-1:0])))
		else $error("strobe did not load burst address");

	// without advance the burst address holds
	chk_burst_hold: assert property (
		@(posedge ref_clk) disable iff (rst)
		(active_r && !strobeHit && adv_r) |=> $stable(accAddr))
		else $error("burst address moved without advance");

	// linear order steps the burst offset by one on each advance
	chk_linear_step: assert property (
		@(posedge ref_clk) disable iff (rst)
		(stepHit && linear_r && $stable(linear_r))
			|=> burstLow == BURST_W'($past(burstLow) + BURST_W'(1)))
		else $error("linear burst did not step by one");

	// a whole burst covers four words and wraps to its start
	chk_burst_wrap: assert property (
		@(posedge ref_clk) disable iff (rst)
		(startHit ##1 stepHit [*4]) |=> burstLow == $past(burstLow, 4))
		else $error("burst did not wrap after four words");

	// write lanes: global write forces all, else gated selects
	chk_global_write: assert property (
		@(posedge ref_clk) disable iff (rst)
		(accessNow && !gw_r) |=> accLanes_r == {LANES{1'b1}})
		else $error("global write did not select all bytes");

	chk_byte_write: assert property (
		@(posedge ref_clk) disable iff (rst)
		(accessNow && gw_r) |=> accLanes_r == $past(bwGate_r ? '0 : ~bws_r))
		else $error("written bytes differ from selects");

	// read starting at capture shows data on the output stage three edges on
	chk_first_word: assert property (
		@(posedge ref_clk) disable iff (rst)
		(startHit && (wrLanes == '0) && !sleepSync_r) ##1 !deselHit ##1 !deselHit
			|=> outValid_r)
		else $error("first read word not ready three cycles after strobe");

	// output register carries the array word from one edge before
	chk_read_pipe: assert property (
		@(posedge ref_clk) disable iff (rst)
		readValid_r |=> outData_r == $past(readData_r))
		else $error("output register skipped pipeline stage");

	// deselect ends driving and the burst on the next edge
	chk_deselect_stop: assert property (
		@(posedge ref_clk) disable iff (rst)
		deselHit |=> !outValid_r && !active_r && dqOe_n)
		else $error("deselect did not stop access in one cycle");

	// partial chip selects never start an access
	chk_cs_gate: assert property (
		@(posedge ref_clk) disable iff (rst)
		(strobeHit && !csAll) |=> !accValid_r)
		else $error("access started without all chip selects");

	// enable and sleep gate the drive with no clock
	chk_async_oe: assert property (
		@(posedge ref_clk) disable iff (rst)
		(outputEnable_n || sleepRequest) |-> dqOe_n)
		else $error("pins driven while disabled or asleep");
endmodule // psbp_sram_port

// *** dv/psbp_host_model.sv ***
// processor side bus model that drives the sram port pins
`timescale 1ns/1ps
module psbp_host_model
	import psbp_pkg::*;
(
	// clock
	input  wire logic            ref_clk,
	// strobes, burst control and address
	output logic                 procStb_n,
	output logic                 ctrlStb_n,
	output logic                 adv_n,
	output logic                 linOrder,
	output logic [17:0]          addr,
	// chip selects
	output logic [CS_W-1:0]      cs_n,
	// write controls and data
	output logic                 gw_n,
	output logic                 bwe_n,
	output logic [3:0]           bws_n,
	output logic [35:0]          dq
);
	// idle bus from time zero
	initial begin
		{procStb_n, ctrlStb_n, adv_n, gw_n, bwe_n, bws_n} = '1;
		{linOrder, addr, cs_n, dq} = '0;
	end
	// one bus cycle; st picks strobe: 0 none, 1 processor, 2 controller
	task cyc(input int st, input logic av, input logic [2:0] c, input logic [17:0] a,
		input logic g, input logic be, input logic [3:0] b, input logic [35:0] d);
		@(negedge ref_clk);
		procStb_n = (st != 1);
		ctrlStb_n = (st != 2);
		adv_n = av;
		cs_n = c;
		addr = a;
		{gw_n, bwe_n, bws_n} = {g, be, b};
		dq = (!g || (!be && b != 4'hf)) ? d : ~dq; // released data keeps toggling
	endtask
	// burst order is a static level, changed only between bursts
	task order(input logic l);
		@(negedge ref_clk);
		linOrder = l;
	endtask
endmodule // psbp_host_model

// *** dv/psbp_sram_port_bench.sv ***
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ps
module psbp_sram_port_bench
	import psbp_pkg::*;
;
	logic        ref_clk, rst, outputEnable_n, sleepRequest, dqOe_n;
	logic        procStb_n, ctrlStb_n, adv_n, linOrder, gw_n, bwe_n;
	logic [2:0]  cs_n;
	logic [3:0]  bws_n;
	logic [17:0] addr;
	logic [35:0] dq, dqOut;
	logic [35:0] mem [logic [17:0]];
	int          numErrors = 0;
	int          samplesChecked = 0;
	int          cycles = 0;

	// bus model and device
	psbp_host_model i_host (.ref_clk(ref_clk), .procStb_n(procStb_n), .ctrlStb_n(ctrlStb_n),
		.adv_n(adv_n), .linOrder(linOrder), .addr(addr), .cs_n(cs_n), .gw_n(gw_n),
		.bwe_n(bwe_n), .bws_n(bws_n), .dq(dq));
	psbp_sram_port i_dut (.ref_clk(ref_clk), .rst(rst), .addrIn(addr),
		.processorAddrStrobe_n(procStb_n), .controllerAddrStrobe_n(ctrlStb_n),
		.burstAdvance_n(adv_n), .burstOrderLinear(linOrder),
		.pipelineChipSelect_n(cs_n[0]), .depthChipSelectHi_n(cs_n[1]),
		.depthChipSelectLo_n(cs_n[2]), .byteWriteSelect_n(bws_n), .byteWriteGate_n(bwe_n),
		.globalWrite_n(gw_n), .outputEnable_n(outputEnable_n), .sleepRequest(sleepRequest),
		.dqIn(dq), .dqOut(dqOut), .dqOe_n(dqOe_n));

	// clock and hang guard
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			numErrors++;
			finish_test;
		end
	end

	task finish_test;
		$display("checked %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input logic [35:0] seen, input logic [35:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// burst address of word k from the start address
	function automatic logic [17:0] seq(input logic [17:0] a, input int k);
		logic [1:0] o;
		o = linOrder ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
		return {a[17:2], o};
	endfunction

	// write n words with the controller strobe, tracking lanes in the model
	task wr(input logic [17:0] a, input int n, input logic g, input logic be,
		input logic [3:0] b, input logic [35:0] d);
		logic [3:0]  ln;
		logic [35:0] t;
		ln = !g ? 4'hf : (!be ? ~b : 4'h0);
		for (int k = 0; k < n + 4; k++) begin
			if (k < n) begin
				i_host.cyc(k == 0 ? 2 : 0, k == 0, CS_ALL_ON, a, g, be, b, d + 36'(k));
				t = mem.exists(seq(a, k)) ? mem[seq(a, k)] : '0;
				for (int j = 0; j < 4; j++)
					if (ln[j]) t[j*9+:9] = 9'((d + 36'(k)) >> (j * 9));
				mem[seq(a, k)] = t;
			end else begin
				i_host.cyc(0, 1, CS_ALL_ON, a, 1, 1, 4'hf, '0);
			end
			// word k-4 at the output stage: writes never drive, a gated-off write reads
			if (k >= 4)
				check(36'(dqOe_n), 36'(ln != 4'h0));
		end
		$display("write of %0d words done", n);
	endtask

	// read burst, fourth advance wraps to the start word
	// mode 1 pokes async controls, mode 2..4 deselects one chip select
	task rd(input logic [17:0] a, input int st, input int mode);
		logic [2:0] c;
		for (int i = 0; i < 9; i++) begin
			c = (mode > 1 && i == 4) ? 3'h1 << (mode - 2) : CS_ALL_ON;
			i_host.cyc(i == 0 ? st : int'(c != CS_ALL_ON), i == 0 || i > 4, c, a,
				1, 1, 4'hf, '0);
			if (i >= 4 && (mode < 2 || i == 4)) begin
				check(dqOut, mem[seq(a, i - 4)]);
				check(36'(dqOe_n), 36'h0);
			end
			if (mode > 1 && i >= 6)
				check(36'(dqOe_n), 36'h1);
			if (mode == 1 && i == 5) begin
				outputEnable_n = 1;
				#1 check(36'(dqOe_n), 36'h1);
				outputEnable_n = 0;
				sleepRequest = 1;
				#1 check(36'(dqOe_n), 36'h1);
				sleepRequest = 0;
			end
		end
		$display("read burst mode %0d done", mode);
	endtask

	// processor strobe then controller strobe on the next edge
	task restart(input logic [17:0] a, input logic [17:0] b);
		for (int i = 0; i < 9; i++) begin
			i_host.cyc(i < 2 ? i + 1 : 0, i < 2 || i > 4, CS_ALL_ON, i == 0 ? a : b,
				1, 1, 4'hf, '0);
			if (i == 4) check(dqOut, mem[a]);
			if (i > 4) check(dqOut, mem[seq(b, i - 5)]);
		end
		$display("restart done");
	endtask

	// synced sleep blocks a strobe; no drive appears once sleep is released
	task doze(input logic [17:0] a);
		sleepRequest = 1;
		for (int i = 0; i < 7; i++) begin
			i_host.cyc(i == 2 ? 2 : 0, 1, CS_ALL_ON, a, 1, 1, 4'hf, '0);
			if (i == 3)
				sleepRequest = 0;
			if (i >= 4)
				check(36'(dqOe_n), 36'h1);
		end
		$display("sleep block done");
	endtask

	// main sequence
	initial begin
		rst = 1;
		outputEnable_n = 0;
		sleepRequest = 0;
		repeat (6) @(negedge ref_clk);
		rst = 0;
		check(36'(dqOe_n), 36'h1);
		check(dqOut, '0);
		i_host.order(1);
		wr(18'h00104, 4, 0, 1, 4'hf, 36'h123456780);
		rd(18'h00106, 2, 0);
		i_host.order(0);
		rd(18'h00107, 1, 0);
		wr(18'h00105, 1, 1, 0, 4'he, 36'h0aaaaaaaa);
		wr(18'h00106, 1, 1, 0, 4'hc, 36'h955555555);
		wr(18'h00107, 1, 1, 1, 4'h0, 36'h0f0f0f0f0);
		wr(18'h00104, 1, 0, 1, 4'hf, 36'h3c3c3c3c3);
		rd(18'h00104, 1, 1);
		restart(18'h00104, 18'h00106);
		for (int j = 0; j < 3; j++)
			rd(18'h00104, 1, 2 + j);
		doze(18'h00104);
		finish_test;
	end
endmodule // psbp_sram_port_bench
